// File: see_defs.svh
// Constants for the serial EEPROM instruction front end
//*****************************************************************************
//*****************************************************************************
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH
`define SEE_OP_EXT 2'h0
`define SEE_OP_WRITE 2'h1
`define SEE_OP_READ 2'h2
`define SEE_OP_ERASE 2'h3
`define SEE_EXT_LOCK 2'h0
`define SEE_EXT_FILL 2'h1
`define SEE_EXT_WIPE 2'h2
`define SEE_EXT_UNLOCK 2'h3
`define SEE_ADDR_SMALL 6
`define SEE_ADDR_MIDDLE 8
`define SEE_ADDR_LARGE 10
`define SEE_ADDR_MAX 11
`define SEE_DATA_X16 16
`define SEE_DATA_X8 8
`define SEE_CLK_NS 25
`define SEE_MIN_DESELECT_NS 1000
`define SEE_MIN_DESELECT_CYC ((`SEE_MIN_DESELECT_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS)
`endif

// File: see_pkg.sv
// Types shared by the serial EEPROM instruction front end
`default_nettype none
package see_pkg;
	typedef enum logic [2:0] {
		SEE_CMD_READ,
		SEE_CMD_WRITE,
		SEE_CMD_ERASE,
		SEE_CMD_UNLOCK,
		SEE_CMD_LOCK,
		SEE_CMD_WIPE,
		SEE_CMD_FILL
	} see_cmd_e;
	typedef struct packed {
		see_cmd_e op;
		logic [10:0] addr;
		logic [15:0] data;
	} see_cmd_s;
endpackage : see_pkg
`default_nettype wire

// File: see_sync.sv
// Two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
`default_nettype none
module see_sync #(
	parameter int W = 4
) (
	input wire logic clock, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic [W-1:0] pinIn, // Raw pins from outside
	output logic [W-1:0] level, // Synchronised level
	output logic [W-1:0] rise, // One-cycle rising edge
	output logic [W-1:0] fall // One-cycle falling edge
);
	//*********************************************************************
	// Per-bit synchroniser
	//*********************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : gBit
			logic meta_r;
			logic stab_r;
			logic prev_r;
			// Only stab_r reads meta_r, so edges are found on settled values
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					meta_r <= 1'b0;
					stab_r <= 1'b0;
					prev_r <= 1'b0;
				end else begin
					meta_r <= pinIn[i];
					stab_r <= meta_r;
					prev_r <= stab_r;
				end
			end
			assign level[i] = stab_r;
			assign rise[i] = stab_r & ~prev_r;
			assign fall[i] = ~stab_r & prev_r;
		end
	endgenerate
endmodule : see_sync
`default_nettype wire

// File: see_front_end.sv
// Serial instruction receiver of a three-wire serial EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module see_front_end #(
	parameter int DENSITY = 0 // 0 small, 1 middle, 2 large
) (
	input wire logic clock, // 40 MHz system clock
	input wire logic resetn, // Async reset, active low
	input wire logic selPin, // Select pin, active high
	input wire logic sclkPin, // Serial clock pin from host
	input wire logic dinPin, // Serial data in pin
	input wire logic orgPin, // 1 for x16, 0 for x8
	input wire logic progBusy, // Array programming in progress
	output logic doutPin, // Serial data out
	output logic doutOe, // High while data out is driven
	output logic cmdValid, // One-cycle pulse: instruction decoded
	output see_pkg::see_cmd_s cmdInfo, // Decoded instruction fields
	output logic progStart, // One-cycle pulse: start programming
	output logic progLocked // High while programming is locked
);
	import see_pkg::*;

	//*********************************************************************
	// Pin synchronisers
	//*********************************************************************
	typedef enum logic [2:0] {
		SEE_IDLE, SEE_WAIT, SEE_OPADDR, SEE_DATA, SEE_ARMED, SEE_STATUS, SEE_SPENT
	} see_state_e;

	localparam int ABASE = (DENSITY == 0) ? `SEE_ADDR_SMALL :
		(DENSITY == 1) ? `SEE_ADDR_MIDDLE : `SEE_ADDR_LARGE;

	logic [3:0] pinLvl;
	logic [3:0] pinRise;
	logic [3:0] pinFall;

	see_sync #(.W(4)) uSync (
		.clock(clock),
		.resetn(resetn),
		.pinIn({orgPin, dinPin, sclkPin, selPin}),
		.level(pinLvl),
		.rise(pinRise),
		.fall(pinFall)
	);

	logic selLvl;
	logic din;
	logic orgLvl;
	logic selRise;
	logic selFall;
	logic bitTick;
	assign selLvl = pinLvl[0];
	assign din = pinLvl[2];
	assign orgLvl = pinLvl[3];
	assign selRise = pinRise[0];
	assign selFall = pinFall[0];
	// Work only on sampled clock edges, so a stopped clock simply freezes state
	assign bitTick = pinRise[1] & selLvl & ~selRise;

	//*********************************************************************
	// Frame state
	//*********************************************************************
	see_state_e state_r;
	see_state_e state_nxt;
	logic x16_r;
	logic [4:0] cnt_r;
	logic [28:0] sh_r;
	logic [28:0] shNew;
	logic [3:0] aw;
	logic [4:0] dw;
	logic addrDone;
	logic [1:0] opc;
	logic [1:0] ext;
	logic [10:0] addrNew;
	see_cmd_s cmd_nxt;

	assign aw = 4'(ABASE) + (x16_r ? 4'h0 : 4'h1);
	assign dw = x16_r ? 5'(`SEE_DATA_X16) : 5'(`SEE_DATA_X8);
	assign shNew = {sh_r[27:0], din};
	assign addrDone = (cnt_r == 5'(aw) + 5'h1);
	assign opc = shNew[aw+1 -: 2];
	assign ext = shNew[aw-1 -: 2];
	assign addrNew = 11'(shNew[10:0] & ((11'h1 << aw) - 11'h1));

	// Op-code and extension to one of the seven instructions
	always_comb begin
		cmd_nxt = cmdInfo;
		cmd_nxt.addr = addrNew;
		unique case (opc)
			`SEE_OP_READ: cmd_nxt.op = SEE_CMD_READ;
			`SEE_OP_WRITE: cmd_nxt.op = SEE_CMD_WRITE;
			`SEE_OP_ERASE: cmd_nxt.op = SEE_CMD_ERASE;
			`SEE_OP_EXT: begin
				unique case (ext)
					`SEE_EXT_UNLOCK: cmd_nxt.op = SEE_CMD_UNLOCK;
					`SEE_EXT_LOCK: cmd_nxt.op = SEE_CMD_LOCK;
					`SEE_EXT_WIPE: cmd_nxt.op = SEE_CMD_WIPE;
					`SEE_EXT_FILL: cmd_nxt.op = SEE_CMD_FILL;
				endcase
			end
		endcase
	end

	// Next frame state
	always_comb begin
		state_nxt = state_r;
		if (selFall) begin
			state_nxt = SEE_IDLE;
		end else if (selRise) begin
			state_nxt = progBusy ? SEE_STATUS : SEE_WAIT;
		end else if (bitTick) begin
			unique case (state_r)
				SEE_WAIT: begin
					if (din) begin
						state_nxt = SEE_OPADDR;
					end
				end
				SEE_OPADDR: begin
					if (addrDone) begin
						if (cmd_nxt.op == SEE_CMD_WRITE || cmd_nxt.op == SEE_CMD_FILL) begin
							state_nxt = SEE_DATA;
						end else if (cmd_nxt.op == SEE_CMD_ERASE || cmd_nxt.op == SEE_CMD_WIPE) begin
							state_nxt = SEE_ARMED;
						end else begin
							state_nxt = SEE_SPENT;
						end
					end
				end
				SEE_DATA: begin
					if (cnt_r == dw - 5'h1) begin
						state_nxt = SEE_ARMED;
					end
				end
				// A further clock edge after the last bit forfeits programming
				SEE_ARMED: state_nxt = SEE_SPENT;
				default: state_nxt = state_r;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= SEE_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Organisation is caught at the start of each frame
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			x16_r <= 1'b0;
		end else if (selRise) begin
			x16_r <= orgLvl;
		end
	end

	// Bit counter and shift register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 5'h0;
			sh_r <= 29'h0;
		end else if (selFall || selRise) begin
			cnt_r <= 5'h0;
		end else if (bitTick) begin
			if (state_r == SEE_WAIT) begin
				cnt_r <= 5'h0;
			end else if (state_r == SEE_OPADDR) begin
				sh_r <= shNew;
				cnt_r <= addrDone ? 5'h0 : cnt_r + 5'h1;
			end else if (state_r == SEE_DATA) begin
				sh_r <= shNew;
				cnt_r <= cnt_r + 5'h1;
			end
		end
	end

	//*********************************************************************
	// Decoded outputs
	//*********************************************************************
	// Command record and its pulse
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmdValid <= 1'b0;
			cmdInfo <= '0;
		end else begin
			cmdValid <= 1'b0;
			if (bitTick && state_r == SEE_OPADDR && addrDone) begin
				cmdValid <= 1'b1;
				cmdInfo <= cmd_nxt;
			end else if (bitTick && state_r == SEE_DATA && cnt_r == dw - 5'h1) begin
				cmdInfo.data <= x16_r ? shNew[15:0] : {8'h0, shNew[7:0]};
			end
		end
	end

	// Lock flag, set at reset, changed only by the two lock commands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			progLocked <= 1'b1;
		end else if (bitTick && state_r == SEE_OPADDR && addrDone) begin
			if (cmd_nxt.op == SEE_CMD_UNLOCK) begin
				progLocked <= 1'b0;
			end else if (cmd_nxt.op == SEE_CMD_LOCK) begin
				progLocked <= 1'b1;
			end
		end
	end

	// Programming starts on deselect from the armed state only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			progStart <= 1'b0;
		end else begin
			progStart <= selFall && state_r == SEE_ARMED && !progLocked;
		end
	end

	// Data out: busy status while selected, dummy zero after a read
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			doutPin <= 1'b0;
			doutOe <= 1'b0;
		end else if (state_nxt == SEE_STATUS) begin
			doutPin <= ~progBusy;
			doutOe <= 1'b1;
		end else if (state_nxt == SEE_SPENT && cmdInfo.op == SEE_CMD_READ) begin
			doutPin <= 1'b0;
			doutOe <= 1'b1;
		end else begin
			doutPin <= 1'b0;
			doutOe <= 1'b0;
		end
	end
endmodule : see_front_end
`default_nettype wire

// File: see_front_end_properties.sv
// Port checks for the instruction front end
`timescale 1ns/1ps
`default_nettype none
module see_front_end_properties
	import see_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic selPin, // Select pin
	input wire logic progBusy, // Array busy
	input wire logic doutPin, // Serial out
	input wire logic doutOe, // Serial out enable
	input wire logic cmdValid, // Decode pulse
	input wire see_pkg::see_cmd_s cmdInfo, // Decoded fields
	input wire logic progStart, // Programming start
	input wire logic progLocked // Lock state
);
	//**********
	// Checks
	//**********
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	a_valid_pulse: assert property (cmdValid |=> !cmdValid) else $error("long cmdValid");
	a_op_legal: assert property (cmdValid |-> cmdInfo.op <= SEE_CMD_FILL) else $error("bad op");
	a_start_pulse: assert property (progStart |=> !progStart) else $error("long progStart");
	a_start_desel: assert property (progStart |-> !selPin) else $error("start while selected");
	a_start_unlocked: assert property (progStart |-> !progLocked) else $error("start while locked");
	a_lock_set: assert property (cmdValid && cmdInfo.op == SEE_CMD_LOCK |-> ##[0:2] progLocked) else $error("no lock");
	a_unlock_clr: assert property (cmdValid && cmdInfo.op == SEE_CMD_UNLOCK |-> ##[0:2] !progLocked) else $error("no unlock");
	a_lock_cause: assert property ($changed(progLocked) |-> cmdValid || $past(cmdValid) || $past(cmdValid, 2))
		else $error("lock changed alone");
	a_busy_low: assert property (doutOe && $past(progBusy) |-> !doutPin) else $error("busy not low");
	a_oe_release: assert property ($fell(selPin) |-> ##[1:5] !doutOe) else $error("out kept on");
	c_decode: cover property (cmdValid);
	c_start: cover property (progStart);
	c_busy: cover property (doutOe && !doutPin && progBusy);
endmodule : see_front_end_properties
bind see_front_end see_front_end_properties u_see_front_end_properties (.clock(clock), .resetn(resetn),
	.selPin(selPin), .progBusy(progBusy), .doutPin(doutPin), .doutOe(doutOe), .cmdValid(cmdValid),
	.cmdInfo(cmdInfo), .progStart(progStart), .progLocked(progLocked));
`default_nettype wire

// File: see_host_model.sv
// Host side of the serial link
`timescale 1ns/1ps
`default_nettype none
module see_host_model (
	input wire logic clock, // System clock
	output logic selPin, // Select to device
	output logic sclkPin, // Serial clock to device
	output logic dinPin // Serial data to device
);
	// Serial clock stands still low between frames
	initial begin
		selPin = 1'b0;
		sclkPin = 1'b0;
		dinPin = 1'b0;
	end
	// Sends n bits MSB first at 200 ns per bit; a short n aborts the frame
	task automatic frame(input logic [31:0] bits, input int n, input int stop);
		repeat (2) @(posedge clock);
		selPin <= 1'b1; // Raised while the clock is low
		for (int i = n - 1; i >= 0; i--) begin
			dinPin <= bits[i];
			if (i == stop) repeat (400) @(posedge clock); // Clock halted mid-frame
			repeat (4) @(posedge clock);
			sclkPin <= 1'b1;
			repeat (4) @(posedge clock);
			sclkPin <= 1'b0;
		end
		dinPin <= ~dinPin; // Released line never shows a stale bit
		repeat (4) @(posedge clock);
		selPin <= 1'b0; // Dropped before any further rising clock
		repeat (44) @(posedge clock); // Deselect beyond 1000 ns
	endtask : frame
endmodule : see_host_model
`default_nettype wire

// File: tb_see_front_end.sv
// Self-checking testbench for the instruction front end
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module tb_see_front_end;
	import see_pkg::*;
	logic clock, resetn, orgPin, progBusy, doutPin, doutOe, cmdValid, progStart, progLocked;
	wire logic selPin, sclkPin, dinPin;
	see_cmd_s cmdInfo, got;
	int n_errors = 0, samples_checked = 0, nStart = 0, nValid = 0;
	see_front_end #(.DENSITY(0)) u_see_front_end (.clock(clock), .resetn(resetn), .selPin(selPin),
		.sclkPin(sclkPin), .dinPin(dinPin), .orgPin(orgPin), .progBusy(progBusy), .doutPin(doutPin),
		.doutOe(doutOe), .cmdValid(cmdValid), .cmdInfo(cmdInfo), .progStart(progStart), .progLocked(progLocked));
	see_host_model u_see_host_model (.clock(clock), .selPin(selPin), .sclkPin(sclkPin), .dinPin(dinPin));
	//**********
	// Clock, monitor and helpers
	//**********
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Keeps the last decode and counts pulses
	always @(posedge clock) begin
		if (cmdValid === 1'b1) begin
			got <= cmdInfo;
			nValid++;
		end
		if (progStart === 1'b1) nStart++;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic t_cmd(input logic [31:0] bits, input int n, input see_cmd_e op, input int starts, input int stop);
		int s;
		s = nStart;
		u_see_host_model.frame(bits, n, stop);
		chk("op", 16'(op), 16'(got.op));
		chk("starts", 16'(starts), 16'(nStart - s));
	endtask : t_cmd
	task automatic t_locked();
		chk("locked", 16'h1, 16'(progLocked));
		t_cmd({1'b1, `SEE_OP_ERASE, 6'h2a}, 9, SEE_CMD_ERASE, 0, -1);
		chk("addr", 16'h2a, 16'(got.addr));
	endtask : t_locked
	task automatic t_unlock();
		t_cmd({3'b001, `SEE_OP_EXT, `SEE_EXT_UNLOCK, 4'h5}, 12, SEE_CMD_UNLOCK, 0, -1);
		chk("locked", 16'h0, 16'(progLocked));
	endtask : t_unlock
	task automatic t_ops();
		t_cmd({1'b1, `SEE_OP_EXT, `SEE_EXT_WIPE, 4'h0}, 9, SEE_CMD_WIPE, 1, -1);
		t_cmd({1'b1, `SEE_OP_EXT, `SEE_EXT_FILL, 4'h0, 16'h00ff}, 25, SEE_CMD_FILL, 1, -1);
		t_cmd({1'b1, `SEE_OP_WRITE, 6'h3f, 16'hbeef}, 25, SEE_CMD_WRITE, 1, -1);
		chk("data", 16'hbeef, cmdInfo.data);
		t_cmd({1'b1, `SEE_OP_ERASE, 6'h01}, 9, SEE_CMD_ERASE, 1, 4);
	endtask : t_ops
	task automatic t_late();
		t_cmd({1'b1, `SEE_OP_WRITE, 6'h0c, 16'h5a3c, 1'b0}, 26, SEE_CMD_WRITE, 0, -1);
	endtask : t_late
	task automatic t_abort();
		int v;
		v = nValid;
		u_see_host_model.frame({1'b1, `SEE_OP_READ, 2'h1}, 5, -1);
		chk("aborted", 16'h0, 16'(nValid - v));
		t_cmd({1'b1, `SEE_OP_READ, 6'h15}, 9, SEE_CMD_READ, 0, -1);
		chk("addr", 16'h15, 16'(got.addr));
	endtask : t_abort
	task automatic t_x8();
		@(posedge clock) orgPin <= 1'b0;
		t_cmd({1'b1, `SEE_OP_ERASE, 7'h55}, 10, SEE_CMD_ERASE, 1, -1);
		chk("addr", 16'h55, 16'(got.addr));
		@(posedge clock) orgPin <= 1'b1;
	endtask : t_x8
	task automatic t_busy();
		int v;
		v = nValid;
		@(posedge clock) progBusy <= 1'b1;
		fork
			u_see_host_model.frame({1'b1, `SEE_OP_ERASE, 6'h11}, 9, -1);
			begin
				repeat (40) @(negedge clock);
				chk("busy", 16'h2, 16'({doutOe, doutPin}));
				@(posedge clock) progBusy <= 1'b0;
				repeat (3) @(negedge clock);
				chk("ready", 16'h3, 16'({doutOe, doutPin}));
			end
		join
		chk("ignored", 16'h0, 16'(nValid - v));
	endtask : t_busy
	task automatic t_relock();
		t_cmd({1'b1, `SEE_OP_EXT, `SEE_EXT_LOCK, 4'ha}, 9, SEE_CMD_LOCK, 0, -1);
		t_cmd({1'b1, `SEE_OP_WRITE, 6'h02, 16'h1234}, 25, SEE_CMD_WRITE, 0, -1);
		t_cmd({1'b1, `SEE_OP_READ, 6'h02}, 9, SEE_CMD_READ, 0, -1);
	endtask : t_relock
	task automatic final_report();
		$display("Checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	//**********
	// Sequence and watchdog
	//**********
	initial begin
		resetn = 1'b0;
		orgPin = 1'b1;
		progBusy = 1'b0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		t_locked();
		t_unlock();
		t_ops();
		t_late();
		t_abort();
		t_x8();
		t_busy();
		t_relock();
		final_report();
	end
	// Whole run needs about 66 us
	initial begin
		#400us;
		n_errors++;
		final_report();
	end
endmodule : tb_see_front_end
`default_nettype wire
